//--- logic/i2c_trig_pkg.sv
// Purpose: shared constants for the start/stop trigger block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   register offsets and bit positions
package i2c_trig_pkg;
  localparam logic [7:0] ctl_offset   = 8'h00;
  localparam logic [7:0] flag_offset  = 8'h04;
  localparam logic [7:0] rate_offset  = 8'h08;
  localparam logic [7:0] stat_offset  = 8'h0c;
  localparam int stop_bit     = 0;
  localparam int start_bit    = 1;
  localparam int exit_bit     = 6;
  localparam int enable_bit   = 7;
  localparam int rsv_bit      = 0;
  localparam int fail_bit     = 7;
  localparam logic [15:0] rate_reset = 16'h01f4;
  localparam int sync_stages  = 2;
  localparam int stat_busy_bit  = 3;
  localparam int stat_start_bit = 4;
  localparam int stat_stop_bit  = 5;
endpackage

//--- logic/line_sync.sv
// Purpose: two-stage synchroniser for one pin
// Assumes: async input
// Notes:   first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      q_o  <= 1'b1;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

//--- logic/interval_timer.sv
// Purpose: loadable down counter for rated intervals
// Assumes: load has priority over counting
// Notes:   done is high while count is zero
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
  parameter int width = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [width-1:0] value_i,
  output logic                  done_o
);
  logic [width-1:0] count;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - width'(1);
    end
  end
  assign done_o = (count == '0);
endmodule
`default_nettype wire

//--- logic/i2c_start_stop_trigger.sv
// Purpose: start and stop condition generation for an i2c master
// Assumes: wishbone classic slave; open-drain lines, oe high pulls low
// Notes:
// Function
// - start on free bus: data low with clock high, then clock low
// - bus busy, reservation allowed: hold start, issue once bus frees
// - bus busy, reservation disabled: set failure flag, clear start
// - start trigger clears itself after start generated
// - start cleared by arbitration loss, exit, enable low, reset
// - start trigger ignored while operation enable is zero
// - start trigger at control bit 1 reads back zero
// - stop: data low, clock high or wait, interval, data high
// - no stop condition while stop trigger is zero
// - stop cleared by arbitration loss, stop seen, exit, enable, reset
// - stop trigger at control bit 0 reads back zero
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module i2c_start_stop_trigger #(
  parameter int rate_width = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        arb_lost_i,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             wait_state_o
);
  typedef enum logic [2:0] {
    st_idle      = 3'b000,
    st_start     = 3'b001,
    st_wait      = 3'b010,
    st_stop_low  = 3'b011,
    st_stop_rise = 3'b100,
    st_stop_set  = 3'b101
  } state_type;

  state_type state;
  state_type next_state;
  logic      scl_s;
  logic      sda_s;
  logic      scl_d;
  logic      sda_d;
  logic      bus_busy;
  logic      start_trigger;
  logic      stop_trigger;
  logic      operation_enable;
  logic      reservation_disable;
  logic      start_failure_flag;
  logic [rate_width-1:0] rate;
  logic      timer_load;
  logic      timer_done;
  logic      wr;
  logic      ctl_wr;
  logic      flag_wr;
  logic      rate_wr;
  logic      exit_req;
  logic      start_req;
  logic      stop_req;
  logic      start_seen;
  logic      stop_seen;

  line_sync u_scl (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (scl_i),
    .q_o   (scl_s)
  );

  line_sync u_sda (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sda_i),
    .q_o   (sda_s)
  );

  interval_timer #(.width(rate_width)) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (timer_load),
    .value_i (rate),
    .done_o  (timer_done)
  );

  // bus edge detection on synchronised lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  assign start_seen = scl_s && sda_d && !sda_s;
  assign stop_seen  = scl_s && !sda_d && sda_s;

  // bus busy between another party's start and stop
  always_ff @(posedge clk_i) begin
    if (rst_i || !operation_enable) begin
      bus_busy <= 1'b0;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end else if (start_seen && state == st_idle) begin
      bus_busy <= 1'b1;
    end
  end

  // wishbone decode, one-cycle ack
  assign wr      = cyc_i && stb_i && we_i && !ack_o;
  assign ctl_wr  = wr && adr_i == i2c_trig_pkg::ctl_offset && sel_i[0];
  assign flag_wr = wr && adr_i == i2c_trig_pkg::flag_offset && sel_i[0];
  assign rate_wr = wr && adr_i == i2c_trig_pkg::rate_offset
                   && sel_i[1:0] == 2'b11;
  assign exit_req  = ctl_wr && dat_i[i2c_trig_pkg::exit_bit];
  assign start_req = ctl_wr && dat_i[i2c_trig_pkg::start_bit]
                     && dat_i[i2c_trig_pkg::enable_bit]
                     && operation_enable;
  assign stop_req  = ctl_wr && dat_i[i2c_trig_pkg::stop_bit]
                     && dat_i[i2c_trig_pkg::enable_bit]
                     && operation_enable;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      dat_o <= 32'h0000_0000;
      case (adr_i)
        i2c_trig_pkg::ctl_offset: begin
          // trigger bits always read zero
          dat_o[i2c_trig_pkg::enable_bit] <= operation_enable;
        end
        i2c_trig_pkg::flag_offset: begin
          dat_o[i2c_trig_pkg::rsv_bit]  <= reservation_disable;
          dat_o[i2c_trig_pkg::fail_bit] <= start_failure_flag;
        end
        i2c_trig_pkg::rate_offset: begin
          dat_o[rate_width-1:0] <= rate;
        end
        i2c_trig_pkg::stat_offset: begin
          dat_o[$bits(state_type)-1:0]         <= state;
          dat_o[i2c_trig_pkg::stat_busy_bit]  <= bus_busy;
          dat_o[i2c_trig_pkg::stat_start_bit] <= start_trigger;
          dat_o[i2c_trig_pkg::stat_stop_bit]  <= stop_trigger;
        end
        default: begin
          dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // control and configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operation_enable    <= 1'b0;
      reservation_disable <= 1'b0;
      rate                <= rate_width'(i2c_trig_pkg::rate_reset);
    end else begin
      if (ctl_wr) begin
        operation_enable <= dat_i[i2c_trig_pkg::enable_bit];
      end
      if (flag_wr) begin
        reservation_disable <= dat_i[i2c_trig_pkg::rsv_bit];
      end
      if (rate_wr) begin
        rate <= dat_i[rate_width-1:0];
      end
    end
  end

  // start trigger and failure flag
  always_ff @(posedge clk_i) begin
    if (rst_i || !operation_enable || exit_req || arb_lost_i) begin
      start_trigger <= 1'b0;
    end else if (start_req && bus_busy && reservation_disable) begin
      start_trigger <= 1'b0;
    end else if (start_req) begin
      start_trigger <= 1'b1;
    end else if (state == st_start && timer_done) begin
      start_trigger <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_failure_flag <= 1'b0;
    end else if (start_req && bus_busy && reservation_disable) begin
      start_failure_flag <= 1'b1;
    end else if (flag_wr && !dat_i[i2c_trig_pkg::fail_bit]) begin
      start_failure_flag <= 1'b0;
    end
  end

  // stop trigger
  always_ff @(posedge clk_i) begin
    if (rst_i || !operation_enable || exit_req || arb_lost_i) begin
      stop_trigger <= 1'b0;
    end else if (stop_req) begin
      stop_trigger <= 1'b1;
    end else if (stop_seen) begin
      stop_trigger <= 1'b0;
    end
  end

  // sequencer
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    case (state)
      st_idle: begin
        if (start_trigger && !bus_busy && scl_s && sda_s) begin
          next_state = st_start;
          timer_load = 1'b1;
        end
      end
      st_start: begin
        if (timer_done) begin
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (stop_trigger) begin
          next_state = st_stop_low;
          timer_load = 1'b1;
        end else if (start_trigger) begin
          next_state = st_idle;
        end
      end
      st_stop_low: begin
        if (timer_done) begin
          next_state = st_stop_rise;
        end
      end
      st_stop_rise: begin
        if (scl_s) begin
          next_state = st_stop_set;
          timer_load = 1'b1;
        end
      end
      st_stop_set: begin
        if (timer_done) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !operation_enable || exit_req || arb_lost_i) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // line drivers, oe high pulls the line low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else if (!operation_enable || exit_req || arb_lost_i) begin
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      sda_oe_o <= next_state == st_start || next_state == st_wait
                  || next_state == st_stop_low
                  || next_state == st_stop_rise
                  || next_state == st_stop_set;
      scl_oe_o <= next_state == st_wait || next_state == st_stop_low;
    end
  end
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign wait_state_o = (state == st_wait);
endmodule
`default_nettype wire

//--- dv/i2c_trig_asserts.sv
// Purpose: port checker for the start/stop trigger
// Assumes: classic wishbone master, rate of 3 or more
// Notes:   bound to every trigger instance
`timescale 1ns/1ps
`default_nettype none
module i2c_trig_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        arb_lost_i,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        wait_state_o
);
  logic wr_ctl;
  logic stop_pend;
  logic sda_oe_d;
  assign wr_ctl = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
    && adr_i == i2c_trig_pkg::ctl_offset;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_oe_d <= 1'b0;
    end else begin
      sda_oe_d <= sda_oe_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || (sda_oe_d && !sda_oe_o)) begin
      stop_pend <= 1'b0;
    end else if (wr_ctl && dat_i[i2c_trig_pkg::stop_bit]
                 && dat_i[i2c_trig_pkg::enable_bit]) begin
      stop_pend <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack is not a one-cycle answer");
  chk_ctl_reads: assert property (
    cyc_i && stb_i && !we_i && !ack_o && adr_i == i2c_trig_pkg::ctl_offset
    |=> dat_o[i2c_trig_pkg::start_bit] == 1'b0
    && dat_o[i2c_trig_pkg::stop_bit] == 1'b0)
    else $error("trigger bits read back nonzero");
  chk_start_order: assert property ($rose(scl_oe_o) |-> sda_oe_o)
    else $error("clock pulled low before data");
  chk_wait_low: assert property (wait_state_o |-> scl_oe_o)
    else $error("wait state without clock held low");
  chk_start_ignored: assert property (
    wr_ctl && dat_i[i2c_trig_pkg::start_bit]
    && !dat_i[i2c_trig_pkg::enable_bit] && !sda_oe_o
    |=> !sda_oe_o [*8])
    else $error("start acted on while disabled");
  chk_exit_release: assert property (
    wr_ctl && dat_i[i2c_trig_pkg::exit_bit]
    |-> ##[1:8] !scl_oe_o && !sda_oe_o)
    else $error("lines not released on exit");
  chk_stop_cause: assert property (
    $fell(sda_oe_o) && !$past(scl_oe_o) |-> stop_pend)
    else $error("stop made without stop trigger");
  chk_stop_setup: assert property (
    $fell(sda_oe_o) && stop_pend |-> !scl_oe_o && !$past(scl_oe_o, 3))
    else $error("data released before clock was high");
endmodule
bind i2c_start_stop_trigger i2c_trig_asserts i2c_trig_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .arb_lost_i(arb_lost_i), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .wait_state_o(wait_state_o));
`default_nettype wire

//--- dv/i2c_peer.sv
// Purpose: other bus master sharing the two lines
// Assumes: pull-ups on both lines, 125 ns link steps
// Notes:   claim makes a start, free makes a stop
`timescale 1ns/1ps
`default_nettype none
module i2c_peer (
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic hold_scl = 1'b0;
  logic hold_sda = 1'b0;
  // wired-and, released lines pulled high
  assign scl_o = !(scl_oe_i || hold_scl);
  assign sda_o = !(sda_oe_i || hold_sda);
  task automatic claim();
    hold_sda <= 1'b1;
    #125 hold_scl <= 1'b1;
  endtask
  task automatic free();
    #125 hold_scl <= 1'b0;
    #125 hold_sda <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/i2c_start_stop_trigger_tb.sv
// Purpose: register-level test of start and stop generation
// Assumes: rate register set to 4
// Notes:   peer model holds the bus for busy cases
`timescale 1ns/1ps
`default_nettype none
module i2c_start_stop_trigger_tb;
  localparam logic [7:0] ctl = i2c_trig_pkg::ctl_offset;
  localparam logic [7:0] flg = i2c_trig_pkg::flag_offset;
  localparam logic [7:0] rte = i2c_trig_pkg::rate_offset;
  localparam logic [7:0] sts = i2c_trig_pkg::stat_offset;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        arb_lost_i = 1'b0;
  logic [31:0] dat_o, rdata;
  logic        ack_o, scl_i, sda_i, scl_oe_o, sda_oe_o, wait_state_o;
  logic        scl_o, sda_o;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n;
  i2c_start_stop_trigger i2c_start_stop_trigger_inst (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .arb_lost_i(arb_lost_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .wait_state_o(wait_state_o));
  i2c_peer i2c_peer_inst (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
    .scl_o(scl_i), .sda_o(sda_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // wait for one enable to reach v, counting cycles in n
  task automatic await(input bit s, input logic v, input int lim);
    n = 0;
    while ((s ? scl_oe_o : sda_oe_o) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(s ? scl_oe_o : sda_oe_o, v);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    access(1'b0, ctl, 0);
    check(rdata, 0);
    access(1'b0, flg, 0);
    check(rdata, 0);
    access(1'b0, rte, 0);
    check(rdata, i2c_trig_pkg::rate_reset);
    access(1'b0, 8'h10, 0);
    check(rdata, 0);
    check({scl_o, sda_o}, 2'b00);
    access(1'b1, rte, 32'h4);
    access(1'b1, ctl, 32'h02);
    repeat (20) @(posedge clk_i);
    check(sda_oe_o, 0);
    // enable first: a start in the enabling write is not taken
    access(1'b1, ctl, 32'h80);
    access(1'b1, ctl, 32'h82);
    await(1'b0, 1'b1, 20);
    await(1'b1, 1'b1, 50);
    check(n >= 4, 1);
    check(wait_state_o, 1);
    access(1'b0, ctl, 0);
    check(rdata, 32'h0000_0080);
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_start_bit], 0);
    access(1'b1, ctl, 32'h81);
    await(1'b0, 1'b0, 80);
    check({scl_i, sda_i}, 2'b11);
    access(1'b0, ctl, 0);
    check(rdata & 32'h3, 0);
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_stop_bit], 0);
    access(1'b1, flg, 32'h01);
    i2c_peer_inst.claim();
    access(1'b1, ctl, 32'h82);
    access(1'b0, flg, 0);
    check(rdata & 32'h81, 32'h81);
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_start_bit], 0);
    check(sda_oe_o, 0);
    access(1'b1, flg, 32'h01);
    access(1'b0, flg, 0);
    check(rdata & 32'h81, 32'h01);
    access(1'b1, flg, 32'h00);
    access(1'b1, ctl, 32'h82);
    repeat (20) @(posedge clk_i);
    check(sda_oe_o, 0);
    access(1'b0, sts, 0);
    check(rdata & 32'h18, 32'h18);
    arb_lost_i <= 1'b1;
    @(posedge clk_i);
    arb_lost_i <= 1'b0;
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_start_bit], 0);
    access(1'b1, ctl, 32'h82);
    access(1'b1, ctl, 32'h00);
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_start_bit], 0);
    access(1'b1, ctl, 32'h80);
    access(1'b1, ctl, 32'h82);
    repeat (20) @(posedge clk_i);
    check(sda_oe_o, 0);
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_start_bit], 1);
    i2c_peer_inst.free();
    await(1'b0, 1'b1, 80);
    await(1'b1, 1'b1, 80);
    access(1'b0, sts, 0);
    check(rdata[i2c_trig_pkg::stat_start_bit], 0);
    access(1'b1, ctl, 32'hc0);
    repeat (10) @(posedge clk_i);
    check({scl_oe_o, sda_oe_o}, 2'b00);
    final_report();
  end
endmodule
`default_nettype wire
